/* logic/output_ramp_protect_config.sv */
// output ramp sequencer and protection configuration registers
// assumes setpoint, output sense and run bit come from logic on ref_clk_i
//
// Summary of operation
// - target moves in 10 mV steps or the remaining gap
// - step time divided from shared master clock
// - rising slope codes 0..6, 7 reserved
// - bus terminator resets rising slope to slowest
// - bit 3 enables controlled falling turn-off
// - falling slope field selects negative rates
// - ramp register top bit reads zero
// - switching held off until target passes prebias
// - bit 5 picks upper good limit
// - bit 4 picks lower good limit
// - undervolt level maps 75 to 90 percent
// - protection writes only while run is low
// - good, overvolt and undervolt limits scale with current setpoint; the current limit code does not
// - bits 7:5 choose regulation slope
// - bit 4 enables thermal limit compensation
// - bits 3:0 choose current limit setpoint
// - limit codes above 0xB saturate
// - falling rate independent of rising rate
`include "ramp_params.svh"

module output_ramp_protect_config #(
   parameter int SLOW_STEP_CYC = `NS_TO_CYC(`STEP_NS_0)
) (
   input  wire logic        ref_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic        run_i,
   input  wire logic        bus_term_i,
   input  wire logic [11:0] vset_i,
   input  wire logic [11:0] vout_i,
   output logic      [11:0] target_o,
   output logic             switch_en_o,
   output logic             ramp_done_o,
   output logic      [12:0] good_upper_o,
   output logic      [12:0] good_lower_o,
   output logic      [12:0] overvolt_o,
   output logic      [12:0] undervolt_o,
   output logic      [2:0]  regulation_slope_o,
   output logic             thermal_comp_o,
   output logic      [3:0]  limit_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // helper functions

   // step period in clock cycles for a slope code
   function automatic logic [15:0] step_cycles(input logic [2:0] code);
      case (code)
         3'h0:    step_cycles = 16'(SLOW_STEP_CYC);
         3'h1:    step_cycles = 16'(`NS_TO_CYC(`STEP_NS_1));
         3'h2:    step_cycles = 16'(`NS_TO_CYC(`STEP_NS_2));
         3'h3:    step_cycles = 16'(`NS_TO_CYC(`STEP_NS_3));
         3'h4:    step_cycles = 16'(`NS_TO_CYC(`STEP_NS_4));
         3'h5:    step_cycles = 16'(`NS_TO_CYC(`STEP_NS_5));
         3'h6:    step_cycles = 16'(`NS_TO_CYC(`STEP_NS_6));
         default: step_cycles = 16'(`NS_TO_CYC(`STEP_NS_1));
      endcase
   endfunction

   // percentage of the setpoint, 13 bits so 130 percent fits
   function automatic logic [12:0] pct_of(input logic [11:0] v,
                                          input logic [7:0]  p);
      logic [19:0] prod;
      prod   = 20'(v) * 20'(p);
      pct_of = 13'(prod / 20'h00064);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   ramp_pkg::ramp_cfg_type   ramp_q;
   ramp_pkg::prot_cfg_type   prot_q;
   ramp_pkg::clim_cfg_type   clim_q;
   ramp_pkg::ramp_state_type state_q;
   ramp_pkg::ramp_state_type state_d;
   logic [11:0]              target_q;
   logic [11:0]              target_d;
   logic                     switch_q;
   logic                     switch_d;
   logic                     tick;

   // write strobes per register
   wire wr_ramp = reg_wr_i && (reg_addr_i == `ADDR_RAMP);
   wire wr_clim = reg_wr_i && (reg_addr_i == `ADDR_CLIM);
   wire wr_prot = reg_wr_i && (reg_addr_i == `ADDR_PROT) && !run_i;

   wire [6:0] ramp_rst = bus_term_i ? `RAMP_TERM_RST : `RAMP_RST;

   // register writes; terminator strap sampled in the synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         ramp_q <= ramp_rst;
         prot_q <= `PROT_RST;
         clim_q <= `CLIM_RST;
      end else begin
         if (wr_ramp) ramp_q <= reg_wdata_i[6:0];
         if (wr_prot) prot_q <= reg_wdata_i[5:0];
         if (wr_clim) clim_q <= reg_wdata_i;
      end
   end

   wire [7:0] rd_mux = (reg_addr_i == `ADDR_RAMP) ? {1'b0, ramp_q} :
                       (reg_addr_i == `ADDR_PROT) ? {2'b00, prot_q} :
                       (reg_addr_i == `ADDR_CLIM) ? clim_q : 8'h00;

   // read data flop, unmapped reads return zero
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) reg_rdata_o <= 8'h00;
      else if (reg_rd_i) reg_rdata_o <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // ramp sequencer

   // goal follows setpoint, zero when ramping down
   wire [11:0] goal     = (state_q == ramp_pkg::ST_FALL) ? 12'h000 : vset_i;
   wire        going_up = target_q < goal;
   wire [11:0] gap      = going_up ? goal - target_q : target_q - goal;
   // step of 10 mV or the remaining gap
   wire [11:0] step     = (gap < 12'(`STEP_LSB)) ? gap : 12'(`STEP_LSB);
   wire        moving   = (state_q != ramp_pkg::ST_IDLE) && (gap != 12'h000);
   wire [2:0]  slope    = going_up ? ramp_q.rise_slope : ramp_q.fall_slope;
   wire [15:0] period   = step_cycles(slope);
   wire        crossed  = target_q >= vout_i;

   step_timer #(
      .WIDTH (16)
   ) u_step_timer (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .enable_i  (moving),
      .period_i  (period),
      .tick_o    (tick)
   );

   // next state, target and switch enable
   always_comb begin
      state_d  = state_q;
      target_d = target_q;
      switch_d = switch_q;
      if (moving && tick) begin
         target_d = going_up ? target_q + step : target_q - step;
      end
      case (state_q)
         ramp_pkg::ST_IDLE: begin
            target_d = 12'h000;
            switch_d = 1'b0;
            if (run_i) state_d = ramp_pkg::ST_RISE;
         end
         ramp_pkg::ST_RISE, ramp_pkg::ST_HOLD: begin
            if (crossed) switch_d = 1'b1;
            if (state_q == ramp_pkg::ST_RISE && gap == 12'h000) begin
               state_d = ramp_pkg::ST_HOLD;
            end
            if (!run_i) begin
               if (ramp_q.falloff_ramp_control && switch_q) begin
                  state_d = ramp_pkg::ST_FALL;
               end else begin
                  state_d  = ramp_pkg::ST_IDLE;
                  switch_d = 1'b0;
               end
            end
         end
         ramp_pkg::ST_FALL: begin
            if (run_i) begin
               state_d = ramp_pkg::ST_RISE;
            end else if (target_q == 12'h000) begin
               state_d  = ramp_pkg::ST_IDLE;
               switch_d = 1'b0;
            end
         end
         default: begin
            state_d  = ramp_pkg::ST_IDLE;
            switch_d = 1'b0;
         end
      endcase
   end

   // sequencer state flops
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         state_q  <= ramp_pkg::ST_IDLE;
         target_q <= 12'h000;
         switch_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         target_q <= target_d;
         switch_q <= switch_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // thresholds and limit outputs

   wire [7:0] pct_hi = prot_q.good_window_upper ? `PCT_PG_HI_NARROW : `PCT_PG_HI_WIDE;
   wire [7:0] pct_lo = prot_q.good_window_lower ? `PCT_PG_LO_NARROW : `PCT_PG_LO_WIDE;
   wire [7:0] pct_ov = (prot_q.overvolt_level == 2'h0) ? `PCT_OV_0 :
                       (prot_q.overvolt_level == 2'h1) ? `PCT_OV_1 : `PCT_OV_2;
   wire [7:0] pct_uv = (prot_q.undervolt_level == 2'h0) ? `PCT_UV_0 :
                       (prot_q.undervolt_level == 2'h1) ? `PCT_UV_1 :
                       (prot_q.undervolt_level == 2'h2) ? `PCT_UV_2 : `PCT_UV_3;
   wire [3:0] lim_sat = (clim_q.limit_setpoint > `CLIM_MAX) ? `CLIM_MAX
                                                            : clim_q.limit_setpoint;

   // registered outputs
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         good_upper_o       <= 13'h0000;
         good_lower_o       <= 13'h0000;
         overvolt_o         <= 13'h0000;
         undervolt_o        <= 13'h0000;
         regulation_slope_o <= 3'h0;
         thermal_comp_o     <= 1'b1;
         limit_code_o       <= `CLIM_MAX;
         target_o           <= 12'h000;
         switch_en_o        <= 1'b0;
         ramp_done_o        <= 1'b0;
      end else begin
         good_upper_o       <= pct_of(vset_i, pct_hi);
         good_lower_o       <= pct_of(vset_i, pct_lo);
         overvolt_o         <= pct_of(vset_i, pct_ov);
         undervolt_o        <= pct_of(vset_i, pct_uv);
         regulation_slope_o <= clim_q.regulation_slope;
         thermal_comp_o     <= clim_q.thermal_comp_enable;
         limit_code_o       <= lim_sat;
         target_o           <= target_q;
         switch_en_o        <= switch_q;
         ramp_done_o        <= (state_q == ramp_pkg::ST_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   prot_write_lock_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      reg_wr_i && reg_addr_i == `ADDR_PROT && run_i |=> $stable(prot_q))
      else $error("protection register written while running");

   ramp_top_zero_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      reg_rd_i && reg_addr_i == `ADDR_RAMP |=> reg_rdata_o[7] == 1'b0)
      else $error("ramp register top bit read as one");

   target_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $past(state_q) != ramp_pkg::ST_IDLE && target_q > $past(target_q)
      |-> target_q - $past(target_q) <= 12'(`STEP_LSB))
      else $error("ramp step larger than 10 mV");

   step_on_tick_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $past(state_q) != ramp_pkg::ST_IDLE && $changed(target_q) |-> $past(tick))
      else $error("target moved without a timer tick");

   prebias_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $rose(switch_q) |-> $past(target_q) >= $past(vout_i))
      else $error("switching enabled below prebias level");

   fast_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      state_q == ramp_pkg::ST_HOLD && !run_i && !ramp_q.falloff_ramp_control
      |=> state_q == ramp_pkg::ST_IDLE && !switch_q ##1 !switch_en_o)
      else $error("turn-off without falling ramp not immediate");

   good_upper_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      prot_q.good_window_upper |=> good_upper_o == pct_of($past(vset_i), 8'h69))
      else $error("upper good limit not 105 percent");

   good_lower_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !prot_q.good_window_lower |=> good_lower_o == pct_of($past(vset_i), 8'h5A))
      else $error("lower good limit not 90 percent");

   limit_sat_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      wr_clim && reg_wdata_i[3:0] > 4'hB |=> ##1 limit_code_o == 4'hB)
      else $error("current limit code above saturation");

endmodule

/* logic/ramp_params.svh */
// constants for the output ramp and protection configuration block
// assumes a 25 MHz master clock and a 12-bit setpoint with 2.5 mV per lsb
`ifndef RAMP_PARAMS_SVH
`define RAMP_PARAMS_SVH

// register offsets on the configuration port
`define ADDR_PROT        8'h01
`define ADDR_RAMP        8'h03
`define ADDR_CLIM        8'h08

// reset values of the registers
`define RAMP_RST         7'h1C
`define RAMP_TERM_RST    7'h0C
`define PROT_RST         6'h08
`define CLIM_RST         8'h1B
`define CLIM_MAX         4'hB

// clock rate and ramp step size
`define CLK_MHZ          25
`define STEP_MV          10
`define LSB_UV           2500
`define STEP_LSB         ((`STEP_MV * 1000) / `LSB_UV)

// duration of one 10 mV step in ns for each slope code
`define STEP_NS_0        200000
`define STEP_NS_1        100000
`define STEP_NS_2        50000
`define STEP_NS_3        40000
`define STEP_NS_4        20000
`define STEP_NS_5        10000
`define STEP_NS_6        5000
`define NS_TO_CYC(ns)    (((ns) * `CLK_MHZ) / 1000)

// threshold percentages of the setpoint
`define PCT_PG_HI_NARROW 8'h69
`define PCT_PG_HI_WIDE   8'h6E
`define PCT_PG_LO_NARROW 8'h5F
`define PCT_PG_LO_WIDE   8'h5A
`define PCT_OV_0         8'h6E
`define PCT_OV_1         8'h78
`define PCT_OV_2         8'h82
`define PCT_UV_0         8'h4B
`define PCT_UV_1         8'h50
`define PCT_UV_2         8'h55
`define PCT_UV_3         8'h5A

`endif

/* logic/ramp_pkg.sv */
// types shared by the ramp and protection configuration logic
// assumes nothing beyond a SystemVerilog compiler
package ramp_pkg;

   // ramp sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RISE,
      ST_HOLD,
      ST_FALL
   } ramp_state_type;

   // ramp configuration fields, bits 6:0
   typedef struct packed {
      logic [2:0] rise_slope;
      logic       falloff_ramp_control;
      logic [2:0] fall_slope;
   } ramp_cfg_type;

   // protection threshold fields, bits 5:0
   typedef struct packed {
      logic       good_window_upper;
      logic       good_window_lower;
      logic [1:0] overvolt_level;
      logic [1:0] undervolt_level;
   } prot_cfg_type;

   // current limit fields, bits 7:0
   typedef struct packed {
      logic [2:0] regulation_slope;
      logic       thermal_comp_enable;
      logic [3:0] limit_setpoint;
   } clim_cfg_type;

endpackage

/* logic/step_timer.sv */
// step timer: divides the master clock into one tick per ramp step
// assumes the period input is at least one and held while enabled
module step_timer #(
   parameter int WIDTH = 16
) (
   input  wire logic             ref_clk_i,
   input  wire logic             resetn_i,
   input  wire logic             enable_i,
   input  wire logic [WIDTH-1:0] period_i,
   output logic                  tick_o
);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic             wrap;

   // wrap when the count reaches the end of the period
   assign wrap    = enable_i && (count_q >= period_i - WIDTH'(1));
   assign count_d = (!enable_i || wrap) ? '0 : count_q + WIDTH'(1);

   // counter and tick flop
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         count_q <= '0;
         tick_o  <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_o  <= wrap;
      end
   end

endmodule

/* test/power_manager_model.sv */
// power manager model: drives the configuration port and the run bit
// assumes the bench clock and inputs changed at its falling edge
`include "ramp_params.svh"

module power_manager_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic            run_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // port idle at time zero
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      run_o   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // released lines show the inverse of the last value
   task automatic release_bus();
      addr_o  = ~addr_o;
      wdata_o = ~wdata_o;
   endtask

   // one write strobe held across one rising edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o  = a;
      wdata_o = d;
      wr_o    = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      release_bus();
   endtask

   // read strobe, data taken once the registered answer has landed
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o   = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      release_bus();
      @(negedge clk_i);
      d = rdata_i;
   endtask

   task automatic set_limit(input logic [3:0] code);
      logic [7:0] v;
      read_reg(`ADDR_CLIM, v);
      write_reg(`ADDR_CLIM, {v[7:4], code});
   endtask

   // run bit changes at a falling edge
   task automatic set_run(input logic r);
      @(negedge clk_i);
      run_o = r;
   endtask
endmodule

/* test/output_ramp_protect_config_tb.sv */
// bench for the ramp and protection configuration block
// assumes the power manager model and a 25 MHz master clock
`include "ramp_params.svh"

module output_ramp_protect_config_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        ref_clk;
   logic        resetn;
   logic        bus_term;
   logic [11:0] vset;
   logic [11:0] vout;
   logic [7:0]  addr, wdata, rdata;
   logic        wr, rd, run, sw_en, done, tcomp;
   logic [11:0] target;
   logic [12:0] gu, gl, ov, uv;
   logic [2:0]  slope;
   logic [3:0]  lcode;
   int          bad_count = 0;
   int          samples_checked = 0;
   int          ovp[4] = '{110, 120, 130, 130};
   int          uvp[4] = '{75, 80, 85, 90};

   // 40 ns master clock
   always #20 ref_clk = ~ref_clk;

   output_ramp_protect_config #(.SLOW_STEP_CYC(50)) dut (
      .ref_clk_i(ref_clk), .resetn_i(resetn), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .run_i(run), .bus_term_i(bus_term), .vset_i(vset), .vout_i(vout),
      .target_o(target), .switch_en_o(sw_en), .ramp_done_o(done),
      .good_upper_o(gu), .good_lower_o(gl), .overvolt_o(ov), .undervolt_o(uv),
      .regulation_slope_o(slope), .thermal_comp_o(tcomp), .limit_code_o(lcode)
   );

   power_manager_model pm (
      .clk_i(ref_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .run_o(run)
   );

   ////////////////////////////////////////////////////////////////////////////
   // compare, count and report
   task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // counts, verdict and end of run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // percentage of the setpoint, rounded down
   function automatic logic [12:0] pct(input logic [11:0] v, input int p);
      return 13'((int'(v) * p) / 100);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset held three cycles with the terminator strap given
   task automatic test_reset(input logic term, input logic [7:0] exp_ramp);
      logic [7:0] v;
      @(negedge ref_clk);
      bus_term = term;
      resetn = 1'b0;
      repeat (3) @(negedge ref_clk);
      resetn = 1'b1;
      pm.read_reg(`ADDR_RAMP, v);
      chk(13'(v), 13'(exp_ramp), "ramp reset");
      pm.read_reg(`ADDR_PROT, v);
      chk(13'(v), 13'h08, "prot reset");
      pm.read_reg(`ADDR_CLIM, v);
      chk(13'(v), 13'h1B, "limit reset");
      pm.read_reg(8'h02, v);
      chk(13'(v), 13'h00, "unmapped read");
      chk(13'(tcomp), 13'h1, "thermal reset");
      $display("test reset done");
   endtask

   // reserved bits, saturation and slope preservation
   task automatic test_fields();
      logic [7:0] v;
      pm.write_reg(`ADDR_RAMP, 8'hFF);
      pm.read_reg(`ADDR_RAMP, v);
      chk(13'(v), 13'h7F, "ramp top bit");
      pm.write_reg(`ADDR_PROT, 8'hFF);
      pm.read_reg(`ADDR_PROT, v);
      chk(13'(v), 13'h3F, "prot top bits");
      pm.write_reg(`ADDR_CLIM, 8'hEF);
      pm.read_reg(`ADDR_CLIM, v);
      chk(13'(v), 13'hEF, "limit reg");
      chk(13'(lcode), 13'hB, "limit saturates");
      chk(13'(slope), 13'h7, "slope");
      chk(13'(tcomp), 13'h0, "thermal off");
      pm.set_limit(4'h1);
      repeat (2) @(negedge ref_clk);
      chk(13'(lcode), 13'h1, "limit code");
      chk(13'(slope), 13'h7, "slope kept");
      $display("test fields done");
   endtask

   // four thresholds against the setpoint
   task automatic chk_limits(input logic [5:0] p);
      repeat (3) @(negedge ref_clk);
      chk(gu, pct(vset, p[5] ? 105 : 110), "good upper");
      chk(gl, pct(vset, p[4] ? 95 : 90), "good lower");
      chk(ov, pct(vset, ovp[p[3:2]]), "overvolt");
      chk(uv, pct(vset, uvp[p[1:0]]), "undervolt");
   endtask

   // every threshold code, then a setpoint move
   task automatic test_limits();
      logic [5:0] pv[4] = '{6'h00, 6'h15, 6'h2A, 6'h3F};
      vset = 12'h3E8;
      foreach (pv[i]) begin
         pm.write_reg(`ADDR_PROT, {2'b00, pv[i]});
         chk_limits(pv[i]);
      end
      vset = 12'h7D0;
      chk_limits(6'h3F);
      $display("test limits done");
   endtask

   // follow the target step by step until the ramp ends
   task automatic watch_ramp(input logic up, input int period);
      logic [11:0] last;
      int          gap, steps;
      last = target;
      gap = 0;
      steps = 0;
      for (int n = 0; n < 2000; n++) begin
         @(negedge ref_clk);
         gap++;
         if (target !== last) begin
            chk(13'(up ? target - last : last - target), 13'h4, "step size");
            if (steps > 0) chk(13'(gap), 13'(period), "step time");
            steps++;
            gap = 0;
            last = target;
         end
         if (up && target < vout) chk(13'(sw_en), 13'h0, "prebias hold");
         if (up ? done === 1'b1 : target === 12'h000) break;
      end
      chk(13'(steps), 13'hA, "step count");
   endtask

   // rising codes 0 and 6, falling code 0, refused write, both turn-off kinds
   task automatic test_ramp();
      logic [7:0] v;
      vset = 12'h028;
      vout = 12'h014;
      pm.write_reg(`ADDR_RAMP, 8'h08);
      pm.set_run(1'b1);
      watch_ramp(1'b1, 50);
      chk(13'(target), 13'h028, "rise end");
      chk(13'(sw_en), 13'h1, "switch on");
      pm.write_reg(`ADDR_PROT, 8'h00);
      pm.read_reg(`ADDR_PROT, v);
      chk(13'(v), 13'h3F, "prot locked");
      pm.set_run(1'b0);
      repeat (3) @(negedge ref_clk);
      chk(13'(sw_en), 13'h1, "soft off");
      watch_ramp(1'b0, 50);
      repeat (3) @(negedge ref_clk);
      chk(13'(sw_en), 13'h0, "off after fall");
      chk(13'(done), 13'h0, "done cleared");
      vout = 12'h000;
      pm.write_reg(`ADDR_RAMP, 8'h60);
      pm.set_run(1'b1);
      watch_ramp(1'b1, `NS_TO_CYC(`STEP_NS_6));
      pm.set_run(1'b0);
      repeat (3) @(negedge ref_clk);
      chk(13'(sw_en), 13'h0, "hard off");
      $display("test ramp done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      bus_term = 1'b0;
      vset = 12'h000;
      vout = 12'h000;
      test_reset(1'b1, 8'h0C);
      test_reset(1'b0, 8'h1C);
      test_fields();
      test_limits();
      test_ramp();
      give_verdict();
   end

   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
